// File: inc/cia_pkg.sv
// constants, types and helpers for the interrupt acknowledge read path
// assumes one core clock; all callers write cia_pkg::name
package cia_pkg;
   // system encoding fields
   localparam logic [1:0]  OP0_SYS   = 2'h3;
   localparam logic [2:0]  OP1_SYS   = 3'h0;
   localparam logic [3:0]  CRN_IF    = 4'hC;
   localparam logic [3:0]  CRM_GRP0  = 4'h8;
   localparam logic [3:0]  CRM_GRP1  = 4'hC;
   localparam logic [2:0]  OP2_ACK   = 3'h0;
   localparam logic [2:0]  OP2_PEEK  = 3'h2;
   // result layout
   localparam int          ID_W      = 24;
   localparam int          DATA_W    = 64;
   localparam logic [23:0] ID16_MASK = 24'h00FFFF;
   localparam logic [23:0] ID24_MASK = 24'hFFFFFF;
   localparam logic [39:0] RSVD_ZERO = 40'h0000000000;
   // special identifiers
   localparam logic [23:0] SPEC_SECURE = 24'h0003FC;
   localparam logic [23:0] SPEC_NONSEC = 24'h0003FD;
   localparam logic [23:0] SPEC_NONE   = 24'h0003FF;
   // privilege levels and trap syndrome
   localparam logic [1:0]  LVL_USER   = 2'h0;
   localparam logic [1:0]  LVL_KERNEL = 2'h1;
   localparam logic [1:0]  LVL_HYP    = 2'h2;
   localparam logic [1:0]  LVL_MON    = 2'h3;
   localparam logic [5:0]  TRAP_CLASS = 6'h18;
   // cycles for activation to reach exception signalling
   localparam logic [1:0]  SETTLE_CYCLES = 2'h3;
   localparam logic [1:0]  CNT_ONE       = 2'h1;
   localparam logic [1:0]  CNT_ZERO      = 2'h0;

   typedef enum logic [1:0] {
      CIA_ROUTE_UNDEF,
      CIA_ROUTE_TRAP,
      CIA_ROUTE_VIRT,
      CIA_ROUTE_PHYS
   } cia_route_t;

   typedef enum logic {
      CIA_ST_IDLE,
      CIA_ST_SYNC
   } cia_state_t;

   // keep only the implemented identifier bits
   function automatic logic [23:0] cia_trim_id(input logic [23:0] id,
                                               input logic        wide);
      cia_trim_id = id & (wide ? ID24_MASK : ID16_MASK);
   endfunction

   // match one register encoding
   function automatic logic cia_enc_match(input logic [1:0] op0,
                                          input logic [2:0] op1,
                                          input logic [3:0] crn,
                                          input logic [3:0] crm,
                                          input logic [2:0] op2,
                                          input logic [3:0] crm_want,
                                          input logic [2:0] op2_want);
      cia_enc_match = (op0 == OP0_SYS) && (op1 == OP1_SYS) &&
                      (crn == CRN_IF) && (crm == crm_want) &&
                      (op2 == op2_want);
   endfunction
endpackage

// File: rtl/cia_access_route.sv
// access routing and trapping for one group's read
// purely combinational; inputs are the core's current control state
`timescale 1ns/1ns
module cia_access_route (
   // access context
   input  wire logic              is_grp1,
   input  wire logic [1:0]        cur_level,
   // interface enables per level
   input  wire logic              sre_kernel,
   input  wire logic              sre_hyp,
   input  wire logic              sre_mon,
   // level presence and width
   input  wire logic              hyp_enabled,
   input  wire logic              hyp_is_64,
   input  wire logic              mon_present,
   input  wire logic              mon_is_64,
   // hypervisor and monitor controls
   input  wire logic              trap_all_group_zero,
   input  wire logic              trap_all_group_one,
   input  wire logic              fast_virtual_route,
   input  wire logic              normal_virtual_route,
   input  wire logic              fast_route_to_monitor,
   input  wire logic              normal_route_to_monitor,
   // decision
   output cia_pkg::cia_route_t    route,
   output logic [1:0]             trap_level
);
   logic hyp64;
   logic mon64;
   logic trap_all;
   logic vroute;
   logic monroute;

   assign hyp64    = hyp_enabled & hyp_is_64;
   assign mon64    = mon_present & mon_is_64;
   assign trap_all = is_grp1 ? trap_all_group_one : trap_all_group_zero;
   assign vroute   = is_grp1 ? normal_virtual_route : fast_virtual_route;
   assign monroute = is_grp1 ? normal_route_to_monitor
                             : fast_route_to_monitor;

   always_comb begin
      route      = cia_pkg::CIA_ROUTE_PHYS;
      trap_level = cia_pkg::LVL_KERNEL;
      case (cur_level)
         cia_pkg::LVL_USER: begin
            route = cia_pkg::CIA_ROUTE_UNDEF;
         end
         cia_pkg::LVL_KERNEL: begin
            if (!sre_kernel) begin
               route = cia_pkg::CIA_ROUTE_TRAP;
            end else if (hyp64 && trap_all) begin
               route      = cia_pkg::CIA_ROUTE_TRAP;
               trap_level = cia_pkg::LVL_HYP;
            end else if (hyp64 && vroute) begin
               route = cia_pkg::CIA_ROUTE_VIRT;
            end else if (mon64 && monroute) begin
               route      = cia_pkg::CIA_ROUTE_TRAP;
               trap_level = cia_pkg::LVL_MON;
            end
         end
         cia_pkg::LVL_HYP: begin
            if (!sre_hyp) begin
               route      = cia_pkg::CIA_ROUTE_TRAP;
               trap_level = cia_pkg::LVL_HYP;
            end else if (mon64 && monroute) begin
               route      = cia_pkg::CIA_ROUTE_TRAP;
               trap_level = cia_pkg::LVL_MON;
            end
         end
         default: begin
            if (!sre_mon) begin
               route      = cia_pkg::CIA_ROUTE_TRAP;
               trap_level = cia_pkg::LVL_MON;
            end
         end
      endcase
   end
endmodule

// File: rtl/cia_id_select.sv
// picks the identifier or special identifier for one group
// pending inputs come from the neighbouring priority selection
`timescale 1ns/1ns
module cia_id_select (
   // configuration
   input  wire logic        id_wide,
   // highest pending interrupt of this group
   input  wire logic        pend_valid,
   input  wire logic        pend_ok,
   input  wire logic        pend_secure_only,
   input  wire logic        pend_nonsec_only,
   input  wire logic [23:0] pend_id,
   // result
   output logic [23:0]      result_id,
   output logic             result_valid
);
   always_comb begin
      result_valid = 1'b0;
      if (pend_valid && pend_ok) begin
         result_id    = cia_pkg::cia_trim_id(pend_id, id_wide);
         result_valid = 1'b1;
      end else if (pend_valid && pend_secure_only) begin
         result_id = cia_pkg::SPEC_SECURE;
      end else if (pend_valid && pend_nonsec_only) begin
         result_id = cia_pkg::SPEC_NONSEC;
      end else begin
         result_id = cia_pkg::SPEC_NONE;
      end
   end
endmodule

// File: rtl/cia_ack_top.sv
// acknowledge and pending-peek read path of the cpu interface
// one read at a time; pending selection updates within settle cycles
`timescale 1ns/1ns
module cia_ack_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // read request from the processing element
   input  wire logic        rd_req,
   input  wire logic [1:0]  rd_op0,
   input  wire logic [2:0]  rd_op1,
   input  wire logic [3:0]  rd_crn,
   input  wire logic [3:0]  rd_crm,
   input  wire logic [2:0]  rd_op2,
   // processing element state
   input  wire logic [1:0]  cur_level,
   input  wire logic [1:0]  core_interrupt_masks,
   // control bits
   input  wire logic        id_width_field,
   input  wire logic        sre_kernel,
   input  wire logic        sre_hyp,
   input  wire logic        sre_mon,
   input  wire logic        hyp_enabled,
   input  wire logic        hyp_is_64,
   input  wire logic        mon_present,
   input  wire logic        mon_is_64,
   input  wire logic        trap_all_group_zero,
   input  wire logic        trap_all_group_one,
   input  wire logic        fast_virtual_route,
   input  wire logic        normal_virtual_route,
   input  wire logic        fast_route_to_monitor,
   input  wire logic        normal_route_to_monitor,
   // group 0 highest pending
   input  wire logic        g0_pend_valid,
   input  wire logic        g0_pend_ok,
   input  wire logic        g0_pend_secure_only,
   input  wire logic        g0_pend_nonsec_only,
   input  wire logic [23:0] g0_pend_id,
   input  wire logic        g0_signal,
   // group 1 highest pending
   input  wire logic        g1_pend_valid,
   input  wire logic        g1_pend_ok,
   input  wire logic        g1_pend_secure_only,
   input  wire logic        g1_pend_nonsec_only,
   input  wire logic [23:0] g1_pend_id,
   input  wire logic        g1_signal,
   // virtual interface values
   input  wire logic [23:0] virtual_group0_ack,
   input  wire logic [23:0] virtual_group1_ack,
   input  wire logic [23:0] virtual_group1_peek,
   // read answer
   output logic             rd_busy,
   output logic             rd_done,
   output logic [63:0]      rd_data,
   output logic             rd_undef,
   output logic             rd_trap,
   output logic [1:0]       rd_trap_level,
   output logic [5:0]       rd_trap_class,
   // activation to the interrupt state
   output logic             activate,
   output logic [23:0]      activate_id,
   output logic             activate_grp1,
   output logic             virt_ack_grp0,
   output logic             virt_ack_grp1,
   // exception requests to the core
   output logic             fast_irq_req,
   output logic             normal_irq_req
);
   logic                  hit_g0_ack;
   logic                  hit_g1_ack;
   logic                  hit_g1_peek;
   logic                  is_grp1;
   logic                  is_ack;
   logic                  take;
   logic                  valid_ack;
   logic                  need_sync;
   logic                  hold_g0;
   logic                  hold_g1;
   logic [23:0]           g0_id;
   logic [23:0]           g1_id;
   logic                  g0_valid;
   logic                  g1_valid;
   logic [23:0]           phys_id;
   logic                  phys_valid;
   logic [23:0]           virt_id;
   logic [23:0]           read_id;
   logic [1:0]            route_level;
   cia_pkg::cia_route_t   route;
   cia_pkg::cia_state_t   state_reg;
   logic [1:0]            settle_cnt_reg;
   logic                  settle_grp1_reg;
   logic                  busy_reg;
   logic                  done_reg;
   logic [63:0]           data_reg;
   logic                  undef_reg;
   logic                  trap_reg;
   logic [1:0]            trap_level_reg;
   logic [5:0]            trap_class_reg;
   logic                  act_reg;
   logic [23:0]           act_id_reg;
   logic                  act_grp1_reg;
   logic                  vack0_reg;
   logic                  vack1_reg;
   logic                  fiq_reg;
   logic                  irq_reg;

   // encoding decode
   assign hit_g0_ack  = cia_pkg::cia_enc_match(rd_op0, rd_op1, rd_crn,
                           rd_crm, rd_op2, cia_pkg::CRM_GRP0,
                           cia_pkg::OP2_ACK);
   assign hit_g1_ack  = cia_pkg::cia_enc_match(rd_op0, rd_op1, rd_crn,
                           rd_crm, rd_op2, cia_pkg::CRM_GRP1,
                           cia_pkg::OP2_ACK);
   assign hit_g1_peek = cia_pkg::cia_enc_match(rd_op0, rd_op1, rd_crn,
                           rd_crm, rd_op2, cia_pkg::CRM_GRP1,
                           cia_pkg::OP2_PEEK);
   assign is_grp1 = hit_g1_ack | hit_g1_peek;
   assign is_ack  = hit_g0_ack | hit_g1_ack;
   assign take    = rd_req && (state_reg == cia_pkg::CIA_ST_IDLE) &&
                    (is_ack || hit_g1_peek);

   cia_access_route u_route (
      .is_grp1                 (is_grp1),
      .cur_level               (cur_level),
      .sre_kernel              (sre_kernel),
      .sre_hyp                 (sre_hyp),
      .sre_mon                 (sre_mon),
      .hyp_enabled             (hyp_enabled),
      .hyp_is_64               (hyp_is_64),
      .mon_present             (mon_present),
      .mon_is_64               (mon_is_64),
      .trap_all_group_zero     (trap_all_group_zero),
      .trap_all_group_one      (trap_all_group_one),
      .fast_virtual_route      (fast_virtual_route),
      .normal_virtual_route    (normal_virtual_route),
      .fast_route_to_monitor   (fast_route_to_monitor),
      .normal_route_to_monitor (normal_route_to_monitor),
      .route                   (route),
      .trap_level              (route_level)
   );

   cia_id_select u_sel_g0 (
      .id_wide          (id_width_field),
      .pend_valid       (g0_pend_valid),
      .pend_ok          (g0_pend_ok),
      .pend_secure_only (g0_pend_secure_only),
      .pend_nonsec_only (g0_pend_nonsec_only),
      .pend_id          (g0_pend_id),
      .result_id        (g0_id),
      .result_valid     (g0_valid)
   );

   cia_id_select u_sel_g1 (
      .id_wide          (id_width_field),
      .pend_valid       (g1_pend_valid),
      .pend_ok          (g1_pend_ok),
      .pend_secure_only (g1_pend_secure_only),
      .pend_nonsec_only (g1_pend_nonsec_only),
      .pend_id          (g1_pend_id),
      .result_id        (g1_id),
      .result_valid     (g1_valid)
   );

   // value selection
   assign phys_id    = is_grp1 ? g1_id : g0_id;
   assign phys_valid = is_grp1 ? g1_valid : g0_valid;
   assign virt_id    = cia_pkg::cia_trim_id(!is_grp1 ? virtual_group0_ack :
                          (hit_g1_peek ? virtual_group1_peek :
                           virtual_group1_ack), id_width_field);
   assign read_id    = (route == cia_pkg::CIA_ROUTE_VIRT) ? virt_id : phys_id;
   assign valid_ack  = take && is_ack && phys_valid &&
                       (route == cia_pkg::CIA_ROUTE_PHYS);
   assign need_sync  = valid_ack && (core_interrupt_masks != 2'h0);

   // requests held off while an activation settles
   assign hold_g0 = (valid_ack && !is_grp1) ||
                    ((settle_cnt_reg != cia_pkg::CNT_ZERO) && !settle_grp1_reg);
   assign hold_g1 = (valid_ack && is_grp1) ||
                    ((settle_cnt_reg != cia_pkg::CNT_ZERO) && settle_grp1_reg);

   // sequencing of a read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= cia_pkg::CIA_ST_IDLE;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            cia_pkg::CIA_ST_IDLE: begin
               if (need_sync) begin
                  state_reg <= cia_pkg::CIA_ST_SYNC;
                  busy_reg  <= 1'b1;
               end else if (take) begin
                  done_reg <= 1'b1;
               end
            end
            cia_pkg::CIA_ST_SYNC: begin
               if (settle_cnt_reg == cia_pkg::CNT_ONE) begin
                  state_reg <= cia_pkg::CIA_ST_IDLE;
                  busy_reg  <= 1'b0;
                  done_reg  <= 1'b1;
               end
            end
            default: begin
               state_reg <= cia_pkg::CIA_ST_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

   // settle counter after an activation
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         settle_cnt_reg  <= cia_pkg::CNT_ZERO;
         settle_grp1_reg <= 1'b0;
      end else if (valid_ack) begin
         settle_cnt_reg  <= cia_pkg::SETTLE_CYCLES;
         settle_grp1_reg <= is_grp1;
      end else if (settle_cnt_reg != cia_pkg::CNT_ZERO) begin
         settle_cnt_reg <= settle_cnt_reg - cia_pkg::CNT_ONE;
      end
   end

   // answer capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_reg       <= '0;
         undef_reg      <= 1'b0;
         trap_reg       <= 1'b0;
         trap_level_reg <= cia_pkg::LVL_USER;
         trap_class_reg <= 6'h00;
      end else if (take) begin
         undef_reg      <= (route == cia_pkg::CIA_ROUTE_UNDEF);
         trap_reg       <= (route == cia_pkg::CIA_ROUTE_TRAP);
         trap_level_reg <= route_level;
         trap_class_reg <= (route == cia_pkg::CIA_ROUTE_TRAP) ?
                           cia_pkg::TRAP_CLASS : 6'h00;
         if ((route == cia_pkg::CIA_ROUTE_PHYS) ||
             (route == cia_pkg::CIA_ROUTE_VIRT)) begin
            data_reg <= {cia_pkg::RSVD_ZERO, read_id};
         end else begin
            data_reg <= '0;
         end
      end
   end

   // activation and virtual acknowledge pulses
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         act_reg      <= 1'b0;
         act_id_reg   <= 24'h000000;
         act_grp1_reg <= 1'b0;
         vack0_reg    <= 1'b0;
         vack1_reg    <= 1'b0;
      end else begin
         act_reg   <= valid_ack;
         vack0_reg <= take && hit_g0_ack &&
                      (route == cia_pkg::CIA_ROUTE_VIRT);
         vack1_reg <= take && hit_g1_ack &&
                      (route == cia_pkg::CIA_ROUTE_VIRT);
         if (valid_ack) begin
            act_id_reg   <= phys_id;
            act_grp1_reg <= is_grp1;
         end
      end
   end

   // exception requests withdrawn while the activation settles
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fiq_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         fiq_reg <= g0_signal && !hold_g0;
         irq_reg <= g1_signal && !hold_g1;
      end
   end

   assign rd_busy        = busy_reg;
   assign rd_done        = done_reg;
   assign rd_data        = data_reg;
   assign rd_undef       = undef_reg;
   assign rd_trap        = trap_reg;
   assign rd_trap_level  = trap_level_reg;
   assign rd_trap_class  = trap_class_reg;
   assign activate       = act_reg;
   assign activate_id    = act_id_reg;
   assign activate_grp1  = act_grp1_reg;
   assign virt_ack_grp0  = vack0_reg;
   assign virt_ack_grp1  = vack1_reg;
   assign fast_irq_req   = fiq_reg;
   assign normal_irq_req = irq_reg;

   user_undef_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      take && (cur_level == cia_pkg::LVL_USER) |=>
         done_reg && undef_reg && !trap_reg && !act_reg && (data_reg == '0))
      else $error("unprivileged read not undefined");

   kernel_sre_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      take && (cur_level == cia_pkg::LVL_KERNEL) && !sre_kernel |=>
         trap_reg && (trap_level_reg == cia_pkg::LVL_KERNEL) &&
         (trap_class_reg == cia_pkg::TRAP_CLASS))
      else $error("kernel disabled interface did not trap");

   tall_hyp_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      take && (cur_level == cia_pkg::LVL_KERNEL) && sre_kernel &&
      hyp_enabled && hyp_is_64 && trap_all_group_one && is_grp1 |=>
         trap_reg && (trap_level_reg == cia_pkg::LVL_HYP) && !act_reg)
      else $error("trap all group one not taken to hypervisor");

   mon_route_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      take && (cur_level == cia_pkg::LVL_HYP) && sre_hyp && mon_present &&
      mon_is_64 && fast_route_to_monitor && hit_g0_ack |=>
         trap_reg && (trap_level_reg == cia_pkg::LVL_MON))
      else $error("monitor routing trap missing");

   rsvd_zero_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      done_reg |-> (data_reg[63:24] == cia_pkg::RSVD_ZERO))
      else $error("reserved result bits not zero");

   narrow_id_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      take && !id_width_field |=> (data_reg[23:16] == 8'h00))
      else $error("narrow identifier has upper bits set");

   act_match_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      act_reg |-> (data_reg[23:0] == act_id_reg) && !trap_reg && !undef_reg)
      else $error("activated id differs from returned id");

   special_none_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      take && is_ack && (route == cia_pkg::CIA_ROUTE_PHYS) &&
      !(is_grp1 ? g1_pend_valid : g0_pend_valid) |=>
         !act_reg && (data_reg[23:0] == cia_pkg::SPEC_NONE))
      else $error("no pending interrupt but not special 1023");

   peek_quiet_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      take && hit_g1_peek |=> !act_reg ##1 !act_reg)
      else $error("peek read caused an activation");

   sync_wait_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      need_sync |=> !done_reg [*3] ##1 done_reg)
      else $error("masked acknowledge completed at wrong cycle");

   fiq_drop_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      act_reg && !act_grp1_reg |-> !fiq_reg ##1 !fiq_reg)
      else $error("fast request not withdrawn after acknowledge");
endmodule

// File: verification/cia_pend_model.sv
// neighbour pending state seen by the acknowledge path
// assumes the bench posts pending groups; activate withdraws only the group that activate_grp1 names
`timescale 1ns/1ns
module cia_pend_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // activation from the block, posting from the bench
   input  wire logic       activate,
   input  wire logic       activate_grp1,
   input  wire logic [1:0] post,
   // pending and request level per group
   output logic [1:0]      pend
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         pend <= 2'h0;
      else
         pend <= (pend | post) &
                 ~({2{activate}} & {activate_grp1, ~activate_grp1});
   end
endmodule

// File: verification/cia_ack_top_tb_top.sv
// self-checking bench for the acknowledge read path
// assumes the pending model above as the neighbour
`timescale 1ns/1ns
module cia_ack_top_tb_top;
   logic        clk, rst_b, rd_req, id_width_field, sre_kernel, sre_hyp;
   logic        sre_mon, hyp_enabled, hyp_is_64, mon_present, mon_is_64;
   logic        trap_all_group_zero, trap_all_group_one, fast_virtual_route;
   logic        normal_virtual_route, fast_route_to_monitor;
   logic        normal_route_to_monitor, ok0, ok1, so, nso;
   logic        rd_busy, rd_done, rd_undef, rd_trap, activate, activate_grp1;
   logic        virt_ack_grp0, virt_ack_grp1, fast_irq_req, normal_irq_req;
   logic [1:0]  cur_level, core_interrupt_masks, rd_trap_level, post, pend;
   logic [1:0]  op0;
   logic [3:0]  rd_crm, crn;
   logic [2:0]  rd_op2, op1;
   logic [5:0]  rd_trap_class;
   logic [23:0] pid, vg, activate_id;
   logic [63:0] rd_data;
   logic [31:0] lfsr;
   logic [73:0] e, expq[$];
   int          fail_count, check_count, cyc, na0, na1, nv0, nv1;
   cia_ack_top dut (.clk, .rst_b, .rd_req, .rd_op0(op0), .rd_op1(op1),
      .rd_crn(crn), .rd_crm, .rd_op2, .cur_level, .core_interrupt_masks,
      .id_width_field, .sre_kernel, .sre_hyp, .sre_mon, .hyp_enabled,
      .hyp_is_64, .mon_present, .mon_is_64, .trap_all_group_zero,
      .trap_all_group_one, .fast_virtual_route, .normal_virtual_route,
      .fast_route_to_monitor, .normal_route_to_monitor,
      .g0_pend_valid(pend[0]), .g0_pend_ok(ok0), .g0_pend_secure_only(so),
      .g0_pend_nonsec_only(nso), .g0_pend_id(pid), .g0_signal(pend[0]),
      .g1_pend_valid(pend[1]), .g1_pend_ok(ok1), .g1_pend_secure_only(so),
      .g1_pend_nonsec_only(nso), .g1_pend_id(pid), .g1_signal(pend[1]),
      .virtual_group0_ack(vg), .virtual_group1_ack(vg),
      .virtual_group1_peek(vg), .rd_busy, .rd_done, .rd_data, .rd_undef,
      .rd_trap, .rd_trap_level, .rd_trap_class, .activate, .activate_id,
      .activate_grp1, .virt_ack_grp0, .virt_ack_grp1, .fast_irq_req,
      .normal_irq_req);
   cia_pend_model peer (.clk, .rst_b, .activate, .activate_grp1, .post, .pend);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // level field reads kernel unless the access trapped
   function automatic logic [73:0] ex(input logic [3:0]  f,
                                      input logic [23:0] v);
      ex = {f[3:2], f[2] ? f[1:0] : cia_pkg::LVL_KERNEL,
            f[2] ? cia_pkg::TRAP_CLASS : 6'h00, 40'h0000000000, v};
   endfunction
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [23:0] x, y);
      check_count++;
      if (x !== y) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, x, y);
      end
   endtask
   // one read; an all-ones note means no answer is due
   task automatic acc(input logic [6:0] enc, input logic [73:0] x);
      @(negedge clk);
      {rd_crm, rd_op2} = enc;
      rd_req = 1'b1;
      if (x !== '1) expq.push_back(x);
      @(negedge clk);
      rd_req = 1'b0;
      for (int i = 0; i < 6 && (rd_busy !== 1'b0 || expq.size() > 0); i++)
         @(negedge clk);
   endtask
   task automatic final_report();
      if (expq.size() > 0) fail_count++;
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(negedge clk) begin
      na0 += (activate === 1'b1 && activate_grp1 === 1'b0);
      na1 += (activate === 1'b1 && activate_grp1 === 1'b1);
      nv0 += (virt_ack_grp0 === 1'b1);
      nv1 += (virt_ack_grp1 === 1'b1);
      if (rd_done === 1'b1) begin
         check_count++;
         e = expq.size() > 0 ? expq.pop_front() : '1;
         if (e !== {rd_undef, rd_trap, rd_trap_level, rd_trap_class, rd_data}) begin
            fail_count++;
            $display("ERROR read answer expected %h seen %h", e,
                     {rd_undef, rd_trap, rd_trap_level, rd_trap_class, rd_data});
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      {rd_req, hyp_enabled, hyp_is_64, mon_present, mon_is_64, so, nso} = '0;
      {trap_all_group_zero, trap_all_group_one, fast_virtual_route} = '0;
      {normal_virtual_route, fast_route_to_monitor, normal_route_to_monitor} = '0;
      {id_width_field, sre_kernel, sre_hyp, sre_mon, ok0, ok1} = '1;
      {core_interrupt_masks, post, rd_crm, rd_op2} = '0;
      {op0, op1, crn} = 9'h18C;
      lfsr = 32'h74ED58EA;
      pid = lfsr[23:0];
      vg = lfsr[31:8];
      cur_level = 2'h0;
      rst_b = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      acc(7'h40, ex(4'h8, 24'h0));
      cur_level = 2'h1;
      sre_kernel = 1'b0;
      acc(7'h60, ex(4'h5, 24'h0));
      {sre_kernel, hyp_enabled, hyp_is_64, trap_all_group_zero} = '1;
      acc(7'h40, ex(4'h6, 24'h0));
      {trap_all_group_zero, trap_all_group_one} = 2'h1;
      acc(7'h62, ex(4'h6, 24'h0));
      {trap_all_group_one, fast_virtual_route, normal_virtual_route} = 3'h3;
      acc(7'h60, ex(4'h0, vg));
      acc(7'h40, ex(4'h0, vg));
      {fast_virtual_route, normal_virtual_route} = 2'h0;
      {mon_present, mon_is_64, fast_route_to_monitor} = '1;
      cur_level = 2'h2;
      acc(7'h40, ex(4'h7, 24'h0));
      normal_route_to_monitor = 1'b1;
      acc(7'h62, ex(4'h7, 24'h0));
      sre_hyp = 1'b0;
      acc(7'h60, ex(4'h6, 24'h0));
      cur_level = 2'h3;
      acc(7'h60, ex(4'h0, 24'h0003FF));
      sre_mon = 1'b0;
      acc(7'h40, ex(4'h7, 24'h0));
      {sre_hyp, sre_mon, mon_present, fast_route_to_monitor} = 4'hC;
      normal_route_to_monitor = 1'b0;
      cur_level = 2'h1;
      lfsr = lfsr_next(lfsr);
      pid = lfsr[23:0];
      post = 2'h3;
      @(negedge clk);
      post = 2'h0;
      acc(7'h62, ex(4'h0, pid));
      chk("irq requests", 24'h000003, {22'h000000, fast_irq_req, normal_irq_req});
      core_interrupt_masks = 2'h3;
      acc(7'h60, ex(4'h0, pid));
      chk("irq requests", 24'h000002, {22'h000000, fast_irq_req, normal_irq_req});
      core_interrupt_masks = 2'h0;
      acc(7'h60, ex(4'h0, 24'h0003FF));
      {ok0, so} = 2'h1;
      acc(7'h40, ex(4'h0, 24'h0003FC));
      {so, nso} = 2'h1;
      acc(7'h40, ex(4'h0, 24'h0003FD));
      {ok0, nso, id_width_field} = 3'h4;
      acc(7'h40, ex(4'h0, {8'h00, pid[15:0]}));
      acc(7'h41, '1);
      op1 = 3'h1;
      acc(7'h40, '1);
      {op0, op1} = {2'h2, 3'h0};
      acc(7'h60, '1);
      {op0, crn} = {2'h3, 4'hD};
      acc(7'h62, '1);
      repeat (3) @(negedge clk);
      chk("last ack id", {8'h00, pid[15:0]}, activate_id);
      chk("irq requests", 24'h000000, {22'h000000, fast_irq_req, normal_irq_req});
      chk("pulses", 24'h001111,
          {8'h00, nv1[3:0], nv0[3:0], na1[3:0], na0[3:0]});
      final_report();
   end
endmodule
